// ===== rtl/edsam_pkg.sv
// Purpose: constants for the extended data space page address mapper
// Assumes: 16-bit effective addresses, 24-bit extended addresses
// Notes:   register offsets are word indexes on the plain register port
package edsam_pkg;

  localparam int unsigned EA_W       = 16;
  localparam int unsigned XA_W       = 24;
  localparam int unsigned RPAGE_W    = 10;
  localparam int unsigned WPAGE_W    = 9;
  localparam int unsigned REG_AW     = 4;
  localparam int unsigned REG_DW     = 16;
  localparam int unsigned EA_TOP_BIT = 15;
  localparam int unsigned RPAGE_PSV  = 9;

  localparam logic [REG_AW-1:0] OFF_RPAGE  = 4'h0;
  localparam logic [REG_AW-1:0] OFF_WPAGE  = 4'h1;
  localparam logic [REG_AW-1:0] OFF_STATUS = 4'h2;
  localparam logic [REG_AW-1:0] OFF_MASK   = 4'h3;
  localparam logic [REG_AW-1:0] OFF_TRAPEA = 4'h4;

  localparam logic [RPAGE_W-1:0] RPAGE_RST = 10'h001;
  localparam logic [WPAGE_W-1:0] WPAGE_RST = 9'h001;
  localparam logic [1:0]         MASK_RST  = 2'h0;

  localparam int unsigned ST_RD_TRAP = 0;
  localparam int unsigned ST_WR_TRAP = 1;

  typedef enum logic [1:0] {
    EDSAM_SEL_NONE,
    EDSAM_SEL_BASE,
    EDSAM_SEL_EXT,
    EDSAM_SEL_PSV
  } edsam_sel_t;

endpackage : edsam_pkg

// ===== rtl/edsam_page_reg.sv
// Purpose: one page select register that refuses a write of zero
// Assumes: write strobe is one cycle, data already trimmed to width
// Notes:   a zero page would alias page 0, so it is never stored
`timescale 1ns/10ps
module edsam_page_reg #(
  parameter int unsigned     W   = 9,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          wr_en,
  input  wire logic [W-1:0]  wr_data,
  output logic      [W-1:0]  page_q
);

  logic [W-1:0] page_d;

  always_comb begin
    page_d = page_q;
    if (wr_en && (wr_data != '0)) begin
      page_d = wr_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      page_q <= RST;
    end else begin
      page_q <= page_d;
    end
  end

  a_zero_write_kept : assert property (@(posedge clk) disable iff (reset)
    (wr_en && wr_data == '0) |=> page_q == $past(page_q))
    else $error("zero write changed page register");

  a_page_never_zero : assert property (@(posedge clk) disable iff (reset)
    page_q != '0)
    else $error("page register holds zero");

endmodule : edsam_page_reg

// ===== rtl/edsam_mapper.sv
// Purpose: maps 16-bit effective addresses to 24-bit extended addresses
// Assumes: one access request per cycle from the core address unit
// Notes:   translation is combinational; results and traps are registered
//
// Operation
// - ten bit read page register held
// - nine bit write page register held
// - read page above low fifteen address bits
// - write page above low fifteen address bits
// - lower half always maps to page zero
// - upper half never reaches page zero
// - both page registers reset to one
// - upper access with zero page traps
// - software write of zero is ignored
// - other pages only via upper half
// - each page step adds thirty two kilobytes
`timescale 1ns/10ps
module edsam_mapper
  import edsam_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              acc_valid,
  input  wire logic              acc_write,
  input  wire logic [EA_W-1:0]   effective_address,
  output logic                   xa_valid_q,
  output logic                   xa_write_q,
  output logic      [XA_W-1:0]   extended_data_space_q,
  output logic                   program_space_window_q,
  output logic                   addr_trap_q,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [REG_DW-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [REG_DW-1:0] reg_rdata_q,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // page select registers
  // ----------------------------------------------------------------
  logic [RPAGE_W-1:0] read_page_select;
  logic [WPAGE_W-1:0] write_page_select;
  logic               wr_rpage;
  logic               wr_wpage;

  assign wr_rpage = reg_wr && (reg_addr == OFF_RPAGE);
  assign wr_wpage = reg_wr && (reg_addr == OFF_WPAGE);

  edsam_page_reg #(
    .W   (RPAGE_W),
    .RST (RPAGE_RST)
  ) u_rpage (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (wr_rpage),
    .wr_data (reg_wdata[RPAGE_W-1:0]),
    .page_q  (read_page_select)
  );

  edsam_page_reg #(
    .W   (WPAGE_W),
    .RST (WPAGE_RST)
  ) u_wpage (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (wr_wpage),
    .wr_data (reg_wdata[WPAGE_W-1:0]),
    .page_q  (write_page_select)
  );

  // ----------------------------------------------------------------
  // address translation
  // ----------------------------------------------------------------
  // page and low bits concatenate, so page n lands at n times 32 KB
  function automatic logic [XA_W-1:0] join_page(input logic [8:0] page,
                                                 input logic [EA_W-1:0] ea);
    join_page = {page, ea[EA_TOP_BIT-1:0]};
  endfunction : join_page

  logic [8:0]      page_sel;
  logic            page_zero;
  logic            upper;
  edsam_sel_t      sel;
  logic [XA_W-1:0] xa_d;
  logic            trap_d;

  assign upper = effective_address[EA_TOP_BIT];

  always_comb begin
    page_sel  = acc_write ? write_page_select : read_page_select[8:0];
    page_zero = (page_sel == 9'h000);
    sel       = EDSAM_SEL_NONE;
    xa_d      = '0;
    trap_d    = 1'b0;
    if (acc_valid) begin
      if (!upper) begin
        sel  = EDSAM_SEL_BASE;
        xa_d = {8'h00, effective_address};
      end else if (!acc_write && read_page_select[RPAGE_PSV]) begin
        sel = EDSAM_SEL_PSV;
      end else if (page_zero) begin
        trap_d = 1'b1;
      end else begin
        sel  = EDSAM_SEL_EXT;
        xa_d = join_page(page_sel, effective_address);
      end
    end
  end

  logic xa_valid_d;
  logic psv_d;

  assign xa_valid_d = (sel == EDSAM_SEL_BASE) || (sel == EDSAM_SEL_EXT);
  assign psv_d      = (sel == EDSAM_SEL_PSV);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xa_valid_q             <= 1'b0;
      xa_write_q             <= 1'b0;
      extended_data_space_q  <= '0;
      program_space_window_q <= 1'b0;
      addr_trap_q            <= 1'b0;
    end else begin
      xa_valid_q             <= xa_valid_d;
      xa_write_q             <= acc_valid && acc_write;
      extended_data_space_q  <= xa_d;
      program_space_window_q <= psv_d;
      addr_trap_q            <= trap_d;
    end
  end

  // ----------------------------------------------------------------
  // trap status, mask and captured address
  // ----------------------------------------------------------------
  logic [1:0]      status_q;
  logic [1:0]      status_d;
  logic [1:0]      mask_q;
  logic [1:0]      mask_d;
  logic [1:0]      ev;
  logic [EA_W-1:0] trap_ea_q;
  logic [EA_W-1:0] trap_ea_d;

  always_comb begin
    ev                 = 2'h0;
    ev[ST_RD_TRAP]     = trap_d && !acc_write;
    ev[ST_WR_TRAP]     = trap_d && acc_write;
    status_d           = status_q;
    mask_d             = mask_q;
    trap_ea_d          = trap_ea_q;
    if (reg_wr && reg_addr == OFF_STATUS) begin
      status_d = status_d & ~reg_wdata[1:0];
    end
    // a new trap in the clearing cycle must not be lost
    status_d = status_d | ev;
    if (reg_wr && reg_addr == OFF_MASK) begin
      mask_d = reg_wdata[1:0];
    end
    if (trap_d) begin
      trap_ea_d = effective_address;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_q  <= 2'h0;
      mask_q    <= MASK_RST;
      trap_ea_q <= '0;
    end else begin
      status_q  <= status_d;
      mask_q    <= mask_d;
      trap_ea_q <= trap_ea_d;
    end
  end

  assign irq = |(status_q & mask_q);

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  logic [REG_DW-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_RPAGE:  rdata_d = {6'h00, read_page_select};
        OFF_WPAGE:  rdata_d = {7'h00, write_page_select};
        OFF_STATUS: rdata_d = {14'h0000, status_q};
        OFF_MASK:   rdata_d = {14'h0000, mask_q};
        OFF_TRAPEA: rdata_d = trap_ea_q;
        default:    rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= '0;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_lower_half_map : assert property (@(posedge clk) disable iff (reset)
    (acc_valid && !upper) |=> xa_valid_q &&
      extended_data_space_q == {8'h00, $past(effective_address)})
    else $error("lower half not mapped to page zero");

  a_read_page_join : assert property (@(posedge clk) disable iff (reset)
    (acc_valid && !acc_write && upper && !read_page_select[RPAGE_PSV]
      && read_page_select[8:0] != 9'h000) |=> xa_valid_q &&
      extended_data_space_q == {$past(read_page_select[8:0]),
                                $past(effective_address[14:0])})
    else $error("read extended address wrong");

  a_write_page_join : assert property (@(posedge clk) disable iff (reset)
    (acc_valid && acc_write && upper) |=> xa_valid_q && xa_write_q &&
      extended_data_space_q == {$past(write_page_select),
                                $past(effective_address[14:0])})
    else $error("write extended address wrong");

  a_upper_not_page0 : assert property (@(posedge clk) disable iff (reset)
    (xa_valid_q && extended_data_space_q[23:15] == 9'h000) |->
      !$past(effective_address[EA_TOP_BIT]))
    else $error("upper half reached page zero");

  a_psv_route : assert property (@(posedge clk) disable iff (reset)
    (acc_valid && !acc_write && upper && read_page_select[RPAGE_PSV]) |=>
      program_space_window_q && !xa_valid_q && !addr_trap_q)
    else $error("program window read not routed");

  // write pages have no window bit, so a write never leaves through it
  a_write_not_psv : assert property (@(posedge clk) disable iff (reset)
    (acc_valid && acc_write) |=> !program_space_window_q)
    else $error("write routed to program window");

  a_trap_sets_flag : assert property (@(posedge clk) disable iff (reset)
    addr_trap_q |-> status_q != 2'h0)
    else $error("trap did not set status");

  // a clear in the trap cycle must lose to the new event
  a_rd_trap_wins : assert property (@(posedge clk) disable iff (reset)
    (trap_d && !acc_write) |=> status_q[ST_RD_TRAP])
    else $error("read trap flag lost");

  a_wr_trap_wins : assert property (@(posedge clk) disable iff (reset)
    (trap_d && acc_write) |=> status_q[ST_WR_TRAP])
    else $error("write trap flag lost");

  a_trap_ea_kept : assert property (@(posedge clk) disable iff (reset)
    trap_d |=> trap_ea_q == $past(effective_address))
    else $error("trap address not captured");

  a_status_clear : assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == OFF_STATUS && !trap_d) |=>
      (status_q & $past(reg_wdata[1:0])) == 2'h0)
    else $error("status bit not cleared by a one");

  a_reset_pages : assert property (@(posedge clk)
    $fell(reset) |-> read_page_select == RPAGE_RST
      && write_page_select == WPAGE_RST)
    else $error("page registers not one after reset");

  a_low_bits_kept : assert property (@(posedge clk) disable iff (reset)
    xa_valid_q |-> extended_data_space_q[14:0] == $past(effective_address[14:0]))
    else $error("page step moved the low address bits");

  a_rpage_readback : assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == OFF_RPAGE) |=>
      reg_rdata_q == {6'h00, $past(read_page_select)})
    else $error("read page readback wrong");

  a_wpage_readback : assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == OFF_WPAGE) |=>
      reg_rdata_q == {7'h00, $past(write_page_select)})
    else $error("write page readback wrong");

  a_one_answer : assert property (@(posedge clk) disable iff (reset)
    $past(acc_valid) |-> $onehot({xa_valid_q, program_space_window_q, addr_trap_q}))
    else $error("access did not get exactly one answer");

  a_idle_quiet : assert property (@(posedge clk) disable iff (reset)
    !$past(acc_valid) |-> !xa_valid_q && !xa_write_q && !program_space_window_q
      && !addr_trap_q && extended_data_space_q == '0)
    else $error("answer without an access");

  // read data stand only in the cycle after the strobe
  a_rdata_idle : assert property (@(posedge clk) disable iff (reset)
    !$past(reg_rd) |-> reg_rdata_q == '0)
    else $error("read data outside the answer cycle");

  c_ext_read   : cover property (@(posedge clk) disable iff (reset)
    acc_valid && !acc_write && upper ##1 xa_valid_q);
  c_ext_write  : cover property (@(posedge clk) disable iff (reset)
    acc_valid && acc_write && upper ##1 xa_valid_q);
  c_trap_irq   : cover property (@(posedge clk) disable iff (reset)
    addr_trap_q ##1 irq);
  c_psv_read   : cover property (@(posedge clk) disable iff (reset)
    program_space_window_q);
  c_status_clr : cover property (@(posedge clk) disable iff (reset)
    reg_wr && reg_addr == OFF_STATUS);

endmodule : edsam_mapper

// ===== bench/edsam_core_model.sv
// Purpose: behavioural model of the core address unit feeding the mapper
// Assumes: one access at a time, issued right after a rising edge
// Notes:   idle lines show the inverse of the last value, never a stale copy
`timescale 1ns/10ps
module edsam_core_model
  import edsam_pkg::*;
(
  input  wire logic            clk,
  output logic                 acc_valid,
  output logic                 acc_write,
  output logic      [EA_W-1:0] effective_address
);
  initial begin
    acc_valid         = 1'b0;
    acc_write         = 1'b0;
    effective_address = 16'h0000;
  end

  // page 0 is only ever reached through the lower half
  task automatic access(input logic wr, input logic [EA_W-1:0] ea);
    @(posedge clk);
    acc_valid         <= 1'b1;
    acc_write         <= wr;
    effective_address <= ea;
    @(posedge clk);
    acc_valid         <= 1'b0;
    acc_write         <= ~wr;
    effective_address <= ~ea;
  endtask : access
endmodule : edsam_core_model

// ===== bench/edsam_mapper_tb_top.sv
// Purpose: self-checking bench for the extended address mapper
// Assumes: register port answers one cycle after the read strobe
// Notes:   the trap path cannot be reached, zero pages are never stored
`timescale 1ns/10ps
module edsam_mapper_tb_top
  import edsam_pkg::*;
;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              acc_valid, acc_write, xa_valid_q, xa_write_q, psv_q, trap_q, irq;
  logic [EA_W-1:0]   ea;
  logic [XA_W-1:0]   xa_q;
  logic [REG_AW-1:0] reg_addr = 4'h0;
  logic [REG_DW-1:0] reg_wdata = 16'h0000;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [REG_DW-1:0] rdata_q;
  int                fail_count = 0;
  int                n_checks = 0;

  always #10 clk = ~clk;

  edsam_core_model u_core (.clk(clk), .acc_valid(acc_valid), .acc_write(acc_write),
                           .effective_address(ea));
  edsam_mapper u_dut (.clk(clk), .reset(reset), .acc_valid(acc_valid),
    .acc_write(acc_write), .effective_address(ea), .xa_valid_q(xa_valid_q),
    .xa_write_q(xa_write_q), .extended_data_space_q(xa_q),
    .program_space_window_q(psv_q), .addr_trap_q(trap_q), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata_q),
    .irq(irq));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [XA_W-1:0] seen, input logic [XA_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk({8'h00, rdata_q}, {8'h00, exp});
  endtask : rd_reg

  // one access; outputs land at the taking edge and are checked 1 ns later
  task automatic acc(input logic wr, input logic [EA_W-1:0] a, input logic [XA_W-1:0] exp);
    u_core.access(wr, a);
    #1;
    chk({21'h0, psv_q, xa_valid_q, xa_write_q}, {21'h0, 1'b0, 1'b1, wr});
    chk(xa_q, exp);
    chk({23'h0, trap_q}, 24'h000000);
  endtask : acc

  task automatic end_of_test;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd_reg(OFF_RPAGE, 16'h0001);
    rd_reg(OFF_WPAGE, 16'h0001);
    acc(1'b0, 16'h8123, 24'h008123);
    acc(1'b1, 16'hFFFF, 24'h00FFFF);
    wr_reg(OFF_RPAGE, 16'hFFFF);
    rd_reg(OFF_RPAGE, 16'h03FF);
    wr_reg(OFF_WPAGE, 16'hFFFF);
    rd_reg(OFF_WPAGE, 16'h01FF);
    acc(1'b1, 16'h8000, 24'hFF8000);
    wr_reg(OFF_WPAGE, 16'h0000);
    rd_reg(OFF_WPAGE, 16'h01FF);
    wr_reg(OFF_RPAGE, 16'h0400);
    rd_reg(OFF_RPAGE, 16'h03FF);
    wr_reg(OFF_RPAGE, 16'h0002);
    acc(1'b0, 16'h8123, 24'h010123);
    acc(1'b0, 16'h8000, 24'h010000);
    acc(1'b0, 16'h7FFF, 24'h007FFF);
    acc(1'b1, 16'h0000, 24'h000000);
    wr_reg(OFF_RPAGE, 16'h0200);
    acc(1'b0, 16'h1234, 24'h001234);
    u_core.access(1'b0, 16'h9000);
    #1;
    chk({21'h0, psv_q, xa_valid_q, trap_q}, 24'h000004);
    chk(xa_q, 24'h000000);
    wr_reg(OFF_MASK, 16'h0003);
    rd_reg(OFF_MASK, 16'h0003);
    rd_reg(OFF_STATUS, 16'h0000);
    chk({23'h0, irq}, 24'h000000);
    wr_reg(4'hF, 16'hFFFF);
    rd_reg(4'hF, 16'h0000);
    rd_reg(OFF_TRAPEA, 16'h0000);
    wr_reg(OFF_STATUS, 16'h0003);
    rd_reg(OFF_STATUS, 16'h0000);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_reg(OFF_RPAGE, 16'h0001);
    rd_reg(OFF_WPAGE, 16'h0001);
    rd_reg(OFF_MASK, 16'h0000);
    chk({23'h0, irq}, 24'h000000);
    end_of_test();
  end

  initial begin
    #(20 * 2000);
    fail_count++;
    end_of_test();
  end
endmodule : edsam_mapper_tb_top
